// ===== hdl/ilod_addr_if.sv
// Carrier between the core and the operand address resolver
`timescale 1ns/10ps
interface ilod_addr_if;
  import ilod_pkg::*;
  logic ext_en;
  logic access_bit;
  logic [7:0] file_field;
  logic [ilod_bsr_w-1:0] bank_select_register;
  logic [ilod_addr_w-1:0] sfp;
  logic [ilod_addr_w-1:0] eff_addr;
  logic indexed;
  modport core (output ext_en, access_bit, file_field, bank_select_register, sfp,
    input eff_addr, indexed);
  modport resolver (input ext_en, access_bit, file_field, bank_select_register, sfp,
    output eff_addr, indexed);
endinterface

// ===== hdl/ilod_addr_resolve.sv
// Operand address resolution: bank, access bank or frame-relative
`timescale 1ns/10ps
module ilod_addr_resolve
(
  ilod_addr_if.resolver bus
);
  import ilod_pkg::*;

  logic low_half;

  // Offset form only for access operands in the low part
  assign low_half = (bus.file_field <= ilod_offset_max);
  assign bus.indexed = bus.ext_en && !bus.access_bit && low_half;

  // Frame pointer of zero lands on the plain access bank addresses
  always_comb
  begin
    if (bus.access_bit)
      bus.eff_addr = {bus.bank_select_register, bus.file_field};
    else if (bus.indexed)
      bus.eff_addr = bus.sfp + {4'h0, bus.file_field};
    else if (low_half)
      bus.eff_addr = {4'h0, bus.file_field};
    else
      bus.eff_addr = {ilod_access_hi_bank, bus.file_field};
  end
endmodule

// ===== hdl/ilod_pkg.sv
// Constants shared by the indexed literal offset decode block
package ilod_pkg;
  localparam int ilod_addr_w = 12;
  localparam int ilod_data_w = 8;
  // Register byte offsets on the APB bus
  localparam logic [7:0] ilod_off_ctrl = 8'h00;
  localparam logic [7:0] ilod_off_sfp = 8'h04;
  localparam logic [7:0] ilod_off_acc = 8'h08;
  localparam logic [7:0] ilod_off_status = 8'h0c;
  localparam logic [7:0] ilod_off_instr = 8'h10;
  localparam logic [7:0] ilod_off_mem_addr = 8'h14;
  localparam logic [7:0] ilod_off_mem_data = 8'h18;
  localparam logic [7:0] ilod_off_exec = 8'h1c;
  // Control fields
  localparam int ilod_ctrl_ext_bit = 0;
  localparam int ilod_ctrl_bsr_lsb = 8;
  localparam int ilod_bsr_w = 4;
  localparam logic ilod_ext_reset = 1'b0;
  // Status flag positions
  localparam int ilod_flag_c = 0;
  localparam int ilod_flag_dc = 1;
  localparam int ilod_flag_z = 2;
  localparam int ilod_flag_ov = 3;
  localparam int ilod_flag_n = 4;
  localparam int ilod_flags_w = 5;
  // Addressing limits
  localparam logic [7:0] ilod_offset_max = 8'h5f;
  localparam logic [3:0] ilod_access_hi_bank = 4'hf;
  // Opcode prefixes
  localparam logic [5:0] ilod_op_add = 6'h09;
  localparam logic [3:0] ilod_op_bitset = 4'h8;
  localparam logic [6:0] ilod_op_setall = 7'h34;
  localparam logic [7:0] ilod_all_ones = 8'hff;
  localparam int ilod_op_w = 16;
  // Execution phases of one instruction cycle
  typedef enum logic [2:0] {
    ilod_idle = 3'b000,
    ilod_decode = 3'b001,
    ilod_read = 3'b010,
    ilod_process = 3'b011,
    ilod_write = 3'b100
  } ilod_phase_type;
endpackage

// ===== hdl/ilod_top.sv
// Core slice executing add, bit-set and set-all-ones with indexed operands
//
// What this block does
// - Extended set on: access operand up to 5Fh is offset from frame pointer.
// - Indexed add adds accumulator to byte at frame pointer plus k.
// - Add result goes to accumulator when d is 0, to memory when 1.
// - Add updates negative, overflow, carry, digit carry and zero flags.
// - Indexed bit-set sets bit b at frame pointer plus k, flags unchanged.
// - Indexed set-all-ones writes FFh at frame pointer plus k, flags kept.
// - Extended-set enable resets to 0, disabling extended addressing.
// - Extended off: access bit 0 picks access bank, 1 picks bank register.
// - Offset form only when access bit is 0 and operand is 5Fh or less.
// - Frame pointer 00h resolves like plain access bank addressing.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
module ilod_top
#(
  parameter int mem_depth = 4096
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ilod_pkg::*;

  ilod_addr_if addr_bus ();
  ilod_phase_type phase_reg;
  logic extended_set_enable_reg;
  logic [ilod_bsr_w-1:0] bank_select_register_reg;
  logic [ilod_addr_w-1:0] stack_frame_pointer_reg;
  logic [ilod_data_w-1:0] acc_reg;
  logic [ilod_flags_w-1:0] flags_reg;
  logic [ilod_op_w-1:0] opcode_reg;
  logic [ilod_addr_w-1:0] mem_addr_reg;
  logic [ilod_addr_w-1:0] oper_addr_reg;
  logic [ilod_data_w-1:0] oper_data_reg;
  logic [ilod_data_w-1:0] result_reg;
  logic [ilod_flags_w-1:0] flags_next;
  logic unsupported_reg;
  logic ack_reg;
  logic err_reg;
  logic [31:0] prdata_reg;
  logic [ilod_data_w-1:0] mem [mem_depth];
  logic busy;
  logic do_write;
  logic take;
  logic [31:0] read_mux;
  logic read_err;
  logic is_add;
  logic is_bitset;
  logic is_setall;
  logic [8:0] sum9;
  logic [4:0] low_sum;

  // Operand fields go to the resolver
  assign addr_bus.ext_en = extended_set_enable_reg;
  assign addr_bus.access_bit = opcode_reg[8];
  assign addr_bus.file_field = opcode_reg[7:0];
  assign addr_bus.bank_select_register = bank_select_register_reg;
  assign addr_bus.sfp = stack_frame_pointer_reg;

  ilod_addr_resolve u_resolve (
    .bus (addr_bus.resolver)
  );

  // Opcode classes; all are single-word encodings
  assign is_add = (opcode_reg[15:10] == ilod_op_add);
  assign is_bitset = (opcode_reg[15:12] == ilod_op_bitset);
  assign is_setall = (opcode_reg[15:9] == ilod_op_setall);

  // APB handshake; accesses wait while an instruction is in flight
  assign busy = (phase_reg != ilod_idle);
  assign take = psel && penable && !ack_reg && !busy;
  assign do_write = psel && penable && pwrite && ack_reg;
  assign pready = ack_reg;
  assign prdata = prdata_reg;
  assign pslverr = ack_reg && err_reg;

  // Read data and error are captured on the same edge that raises pready
  always_comb
  begin
    read_mux = 32'h0000_0000;
    read_err = 1'b0;
    case (paddr)
      ilod_off_ctrl:
      begin
        read_mux[ilod_ctrl_ext_bit] = extended_set_enable_reg;
        read_mux[ilod_ctrl_bsr_lsb +: ilod_bsr_w] = bank_select_register_reg;
      end
      ilod_off_sfp: read_mux[ilod_addr_w-1:0] = stack_frame_pointer_reg;
      ilod_off_acc: read_mux[ilod_data_w-1:0] = acc_reg;
      ilod_off_status: read_mux[ilod_flags_w-1:0] = flags_reg;
      ilod_off_instr: read_mux[ilod_op_w-1:0] = opcode_reg;
      ilod_off_mem_addr: read_mux[ilod_addr_w-1:0] = mem_addr_reg;
      ilod_off_mem_data: read_mux[ilod_data_w-1:0] = mem[mem_addr_reg];
      ilod_off_exec:
      begin
        read_mux[0] = busy;
        read_mux[1] = unsupported_reg;
      end
      default: read_err = 1'b1;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= take;
      if (take)
      begin
        err_reg <= read_err;
        prdata_reg <= pwrite ? 32'h0000_0000 : read_mux;
      end
    end
  end

  // Configuration: extended set is off until software enables it
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      extended_set_enable_reg <= ilod_ext_reset;
      bank_select_register_reg <= '0;
      stack_frame_pointer_reg <= '0;
      mem_addr_reg <= '0;
    end
    else if (do_write)
    begin
      if (paddr == ilod_off_ctrl)
      begin
        extended_set_enable_reg <= pwdata[ilod_ctrl_ext_bit];
        bank_select_register_reg <=
          pwdata[ilod_ctrl_bsr_lsb +: ilod_bsr_w];
      end
      if (paddr == ilod_off_sfp)
        stack_frame_pointer_reg <= pwdata[ilod_addr_w-1:0];
      if (paddr == ilod_off_mem_addr)
        mem_addr_reg <= pwdata[ilod_addr_w-1:0];
    end
  end

  // Phase sequencer: a write to the instruction register starts one cycle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      phase_reg <= ilod_idle;
      opcode_reg <= '0;
      unsupported_reg <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        ilod_idle:
          if (do_write && paddr == ilod_off_instr)
          begin
            opcode_reg <= pwdata[ilod_op_w-1:0];
            phase_reg <= ilod_decode;
          end
        ilod_decode:
        begin
          unsupported_reg <= !(is_add || is_bitset || is_setall);
          phase_reg <= ilod_read;
        end
        ilod_read: phase_reg <= ilod_process;
        ilod_process: phase_reg <= ilod_write;
        ilod_write: phase_reg <= ilod_idle;
        default: phase_reg <= ilod_idle;
      endcase
    end
  end

  // Adder with nibble carry for the digit-carry flag
  assign sum9 = {1'b0, acc_reg} + {1'b0, oper_data_reg};
  assign low_sum = {1'b0, acc_reg[3:0]} + {1'b0, oper_data_reg[3:0]};

  always_comb
  begin
    flags_next = flags_reg;
    flags_next[ilod_flag_c] = sum9[8];
    flags_next[ilod_flag_dc] = low_sum[4];
    flags_next[ilod_flag_z] = (sum9[7:0] == 8'h00);
    flags_next[ilod_flag_ov] = (acc_reg[7] == oper_data_reg[7]) &&
      (sum9[7] != acc_reg[7]);
    flags_next[ilod_flag_n] = sum9[7];
  end

  // Operand address is latched at decode, data at read
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      oper_addr_reg <= '0;
      oper_data_reg <= '0;
    end
    else
    begin
      if (phase_reg == ilod_decode)
        oper_addr_reg <= addr_bus.eff_addr;
      if (phase_reg == ilod_read)
        oper_data_reg <= mem[oper_addr_reg];
    end
  end

  // Result computed in the process phase
  always_ff @(posedge clock)
  begin
    if (reset)
      result_reg <= '0;
    else if (phase_reg == ilod_process)
    begin
      if (is_add)
        result_reg <= sum9[7:0];
      else if (is_bitset)
        result_reg <= oper_data_reg |
          (8'h01 << opcode_reg[11:9]);
      else
        result_reg <= ilod_all_ones;
    end
  end

  // Accumulator and flags; only the add and a status register write touch the flags
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      acc_reg <= '0;
      flags_reg <= '0;
    end
    else if (do_write && paddr == ilod_off_acc)
      acc_reg <= pwdata[ilod_data_w-1:0];
    else if (do_write && paddr == ilod_off_status)
      flags_reg <= pwdata[ilod_flags_w-1:0];
    else if (phase_reg == ilod_process && is_add)
    begin
      flags_reg <= flags_next;
      if (!opcode_reg[9])
        acc_reg <= sum9[7:0];
    end
  end

  // Data memory; no reset so it maps to plain RAM
  always_ff @(posedge clock)
  begin
    if (phase_reg == ilod_write && !unsupported_reg &&
        !(is_add && !opcode_reg[9]))
      mem[oper_addr_reg] <= result_reg;
    else if (do_write && paddr == ilod_off_mem_data)
      mem[mem_addr_reg] <= pwdata[ilod_data_w-1:0];
  end
endmodule

// ===== testbench/ilod_top_properties.sv
// Bus timing checks for the indexed offset decode block
`timescale 1ns/10ps
module ilod_top_check
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Answer is a single-cycle pulse
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready too long");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("pready uncaused");
  // Busy core stalls at most four cycles
  property p_ans; $rose(psel && penable) |-> ##[1:6] pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("lone pslverr");
  property p_unm; pready && paddr > 8'h1c |-> pslverr && prdata == 0;
  endproperty
  a_unm: assert property (p_unm) else $error("hole accepted");
  property p_map; pready && paddr <= 8'h1c && paddr[1:0] == 2'b00
    |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  // Read data only moves when an access completes
  property p_hold; $changed(prdata) |-> pready; endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_rst; disable iff (1'b0) reset |=> !pready && prdata == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind ilod_top ilod_top_check u_chk (.clock(clock), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== testbench/tb.sv
// Self-checking bench: APB access and indexed instruction runs
`timescale 1ns/10ps
module tb;
  import ilod_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic rd_err;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  ilod_top u_ilod_top (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #10 clock = ~clock;
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; idle edge after so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic mwr(input logic [11:0] a, input logic [7:0] d);
    wr(ilod_off_mem_addr, {20'h0, a});
    wr(ilod_off_mem_data, {24'h0, d});
  endtask
  task automatic mchk(input logic [11:0] a, input logic [7:0] e);
    wr(ilod_off_mem_addr, {20'h0, a});
    rchk(ilod_off_mem_data, {24'h0, e});
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rchk(ilod_off_ctrl, 32'h0);
    rchk(8'h20, 32'h0);
    // A hole in the map must be refused, not just read as zero
    chk({31'h0, rd_err}, 32'h1);
    // Extended set off, frame pointer ignored
    wr(ilod_off_sfp, 32'ha00);
    wr(ilod_off_ctrl, 32'h300);
    mwr(12'h010, 8'h00);
    mwr(12'ha10, 8'h00);
    wr(ilod_off_instr, 32'h6810);
    mchk(12'h010, 8'hff);
    mchk(12'ha10, 8'h00);
    mwr(12'h320, 8'h00);
    wr(ilod_off_instr, 32'h6920);
    mchk(12'h320, 8'hff);
    $display("test plain addressing done");
    // Extended set on: add to accumulator, then back to memory
    wr(ilod_off_ctrl, 32'h301);
    wr(ilod_off_acc, 32'h78);
    mwr(12'ha2c, 8'h08);
    wr(ilod_off_instr, 32'h242c);
    rchk(ilod_off_acc, 32'h80);
    mchk(12'ha2c, 8'h08);
    rchk(ilod_off_status, 32'h1a);
    mwr(12'ha2c, 8'h80);
    wr(ilod_off_instr, 32'h262c);
    mchk(12'ha2c, 8'h00);
    rchk(ilod_off_acc, 32'h80);
    rchk(ilod_off_status, 32'h0d);
    $display("test indexed add done");
    mwr(12'ha0a, 8'h55);
    wr(ilod_off_instr, 32'h8e0a);
    mchk(12'ha0a, 8'hd5);
    mwr(12'ha5f, 8'h00);
    wr(ilod_off_instr, 32'h685f);
    mchk(12'ha5f, 8'hff);
    rchk(ilod_off_status, 32'h0d);
    // Offset 60h falls outside the frame window
    mwr(12'hf60, 8'h00);
    wr(ilod_off_instr, 32'h6860);
    mchk(12'hf60, 8'hff);
    wr(ilod_off_sfp, 32'h0);
    mwr(12'h010, 8'h00);
    wr(ilod_off_instr, 32'h6810);
    mchk(12'h010, 8'hff);
    rchk(ilod_off_exec, 32'h0);
    // Undecoded opcode: memory, accumulator and flags stay put
    mwr(12'h010, 8'h12);
    wr(ilod_off_instr, 32'h0010);
    mchk(12'h010, 8'h12);
    rchk(ilod_off_exec, 32'h2);
    rchk(ilod_off_acc, 32'h80);
    rchk(ilod_off_status, 32'h0d);
    // Reset in mid-run must drop the extended set again
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rchk(ilod_off_ctrl, 32'h0);
    rchk(ilod_off_sfp, 32'h0);
    rchk(ilod_off_status, 32'h0);
    $display("test bit-set and set-all done");
    final_report();
  end
endmodule
